// file: core/fbmec_pkg.sv
/*
 * fbmec_pkg: shared types and constants for the buffered-DIMM error classifier.
 * assumes: included before the classifier module; no registers reached by software.
 */
package fbmec_pkg;

    // severity classes, one bit each in the sticky vectors
    localparam int unsigned SEV_W         = 3;
    localparam int unsigned SEV_FATAL_BIT = 0;
    localparam int unsigned SEV_REC_BIT   = 1;
    localparam int unsigned SEV_CORR_BIT  = 2;

    // event vector layout
    localparam int unsigned EV_W          = 10;
    localparam int unsigned EV_FAILOVER   = 0;
    localparam int unsigned EV_DEM_NMIR   = 1;
    localparam int unsigned EV_DEM_MIR    = 2;
    localparam int unsigned EV_SPARE      = 3;
    localparam int unsigned EV_PATROL     = 4;
    localparam int unsigned EV_SYNC_PAR   = 5;
    localparam int unsigned EV_SPD        = 6;
    localparam int unsigned EV_FRST_TMO   = 7;
    localparam int unsigned EV_REFRESH    = 8;
    localparam int unsigned EV_FRST_RED   = 9;

    // reset values
    localparam logic [EV_W-1:0]  EV_RST  = 10'h000;
    localparam logic [SEV_W-1:0] SEV_RST = 3'h0;

    // gearing ratio codes
    localparam logic [1:0] GEAR_1_1 = 2'h0;
    localparam logic [1:0] GEAR_4_5 = 2'h1;
    localparam logic [1:0] GEAR_OTH = 2'h2;

    // northbound frames per gearing window, data frames allowed in 4:5
    localparam logic [2:0] GEAR45_WIN   = 3'h5;
    localparam logic [2:0] GEAR45_SLOTS = 3'h4;

    // fast-reset timeout
    localparam int unsigned FRST_TMO_NS  = 1000;
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned FRST_TMO_CYC = FRST_TMO_NS / CLK_NS;

    // one northbound frame, as seen by the classifier
    typedef struct packed {
        logic       valid;      // frame slot present
        logic       rd_data;    // frame carries read data
        logic       refr_ack;   // frame carries a refresh acknowledgement
        logic       ack_bad;    // that acknowledgement was corrupted
    } fbmec_nb_frame_s;

    // one detected data ECC result
    typedef struct packed {
        logic       corr;       // correctable data error seen
        logic       mirrored;   // demand read in mirrored mode
        logic       spare_copy; // read was a spare copy from failing rank
        logic       patrol;     // read was from the patrol scrubber
    } fbmec_ecc_s;

    // failover log entry
    typedef struct packed {
        logic       branch;     // branch that failed over
        logic       channel;    // channel with the failing lane
        logic [4:0] lane;       // failing bit lane
    } fbmec_fo_log_s;

endpackage : fbmec_pkg

// file: core/fbmec_classifier.sv
/*
 * fbmec_classifier: detects and classifies memory channel errors, raises
 * sticky severity flags, drives failover, replay and fast-reset supervision.
 * assumes: all inputs synchronous to core_clk_i; clear strobes from a host
 * agent outside this block; one branch pair of channels per instance pair.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// - lane failure: enter failover, recoverable, log
// - demand read correctable error: correctable event
// - spare-copy correctable error: distinct correctable event
// - patrol correctable error: distinct correctable event
// - sync status parity error: drop, correctable
// - alert fast-reset prep: replay affected config commands
// - presence-detect error: correctable, no hardware retry
// - non-redundant fast-reset timeout: fatal event
// - non-1:1 gearing: timeout may be suppressed
// - corrupted refresh acknowledgement: recoverable event
// - skip refresh check alongside read data
// - skip refresh check when gearing oversubscribed
// - 4:5 gearing: fifth frame ack unchecked when the first four frames carried read data
module fbmec_classifier
    import fbmec_pkg::*;
#(
    parameter int unsigned TMO_CYC = FRST_TMO_CYC // fast-reset timeout in cycles
) (
    input  wire logic            core_clk_i,        // core clock
    input  wire logic            reset_i,           // sync reset, active high
    input  wire logic            lane_fail_i,       // bit-lane failure pulse
    input  wire fbmec_fo_log_s   lane_info_i,       // where the lane failed
    input  wire fbmec_ecc_s      ecc_i,             // data ECC result
    input  wire logic            sync_stat_i,       // sync status frame arrived
    input  wire logic            sync_par_err_i,    // its parity was bad
    input  wire logic            sync_for_frst_i,   // sync prepares alert fast reset
    input  wire logic            spd_err_i,         // presence-detect protocol error
    input  wire logic            frst_start_i,      // fast reset issued
    input  wire logic            frst_redund_i,     // fast reset is redundant
    input  wire logic            frst_done_i,       // fast reset completed
    input  wire logic            wr_recov_both_i,   // both channels failed wr recovery
    input  wire logic [1:0]      gear_i,            // gearing ratio code
    input  wire fbmec_nb_frame_s nb_i,              // northbound frame slot
    input  wire logic [EV_W-1:0] ev_clr_i,          // event clear strobes
    input  wire logic [SEV_W-1:0] sev_clr_i,        // severity clear strobes
    output logic                 failover_o,        // branch in failover mode
    output var fbmec_fo_log_s    failover_lane_log_low_o,  // failover log, location
    output logic [7:0]           failover_lane_log_high_o, // failover log, count
    output logic                 sync_use_o,        // sync status accepted
    output logic                 cfg_replay_o,      // replay queued config cmds
    output logic [EV_W-1:0]      ev_sticky_o,       // sticky per-event flags
    output logic [SEV_W-1:0]     sev_sticky_o       // sticky severity flags
);

    // per-cycle event detections
    logic [EV_W-1:0] ev_hit;       // raw events this cycle
    logic            ack_checked;  // refresh ack is being checked
    logic            frst_tmo;     // non-redundant timeout reached
    logic            frst_tmo_red; // redundant timeout reached
    logic            tmo_suppress; // gearing may hide the timeout

    // fast-reset supervisor states
    typedef enum logic [2:0] {
        FBMEC_IDLE = 3'b001,
        FBMEC_WAIT = 3'b010,
        FBMEC_DONE = 3'b100
    } fbmec_frst_e;

    fbmec_frst_e      frst_st_r;     // supervisor state
    logic             frst_red_r;    // latched redundancy of reset
    logic [31:0]      frst_cnt_r;    // timeout counter
    logic [2:0]       gear_pos_r;    // frame position in 4:5 window
    logic [2:0]       gear_data_r;   // data frames seen in window

    // maps an event to its severity bit
    function automatic logic [SEV_W-1:0] fbmec_sev(input logic [EV_W-1:0] ev);
        logic [SEV_W-1:0] s;
        s = SEV_RST;
        s[SEV_FATAL_BIT] = ev[EV_FRST_TMO];
        s[SEV_REC_BIT]   = ev[EV_FAILOVER] | ev[EV_REFRESH] | ev[EV_FRST_RED];
        s[SEV_CORR_BIT]  = ev[EV_DEM_NMIR] | ev[EV_DEM_MIR] | ev[EV_SPARE]
                         | ev[EV_PATROL] | ev[EV_SYNC_PAR] | ev[EV_SPD];
        return s;
    endfunction : fbmec_sev

    // 4:5 window tracking of northbound slots
    always_ff @(posedge core_clk_i) begin
        if (reset_i || gear_i != GEAR_4_5) begin
            gear_pos_r  <= 3'h0;
            gear_data_r <= 3'h0;
        end else if (nb_i.valid) begin
            if (gear_pos_r == GEAR45_WIN - 3'h1) begin
                gear_pos_r  <= 3'h0;
                gear_data_r <= 3'h0;
            end else begin
                gear_pos_r  <= gear_pos_r + 3'h1;
                gear_data_r <= gear_data_r + {2'h0, nb_i.rd_data};
            end
        end
    end

    // refresh ack check gating
    always_comb begin
        ack_checked = nb_i.valid && nb_i.refr_ack;
        if (nb_i.rd_data) begin
            ack_checked = 1'b0;
        end
        if (gear_i == GEAR_4_5 && gear_pos_r == GEAR45_WIN - 3'h1
            && gear_data_r >= GEAR45_SLOTS) begin
            ack_checked = 1'b0;
        end
    end

    // gearing other than 1:1 may swallow the non-redundant timeout
    assign tmo_suppress = (gear_i != GEAR_1_1) && wr_recov_both_i;
    assign frst_tmo     = frst_st_r == FBMEC_WAIT && !frst_red_r
                          && frst_cnt_r == TMO_CYC - 1 && !frst_done_i;
    assign frst_tmo_red = frst_st_r == FBMEC_WAIT && frst_red_r
                          && frst_cnt_r == TMO_CYC - 1 && !frst_done_i;

    // raw event detection
    always_comb begin
        ev_hit = EV_RST;
        ev_hit[EV_FAILOVER] = lane_fail_i;
        ev_hit[EV_DEM_NMIR] = ecc_i.corr && !ecc_i.spare_copy && !ecc_i.patrol
                              && !ecc_i.mirrored;
        ev_hit[EV_DEM_MIR]  = ecc_i.corr && !ecc_i.spare_copy && !ecc_i.patrol
                              && ecc_i.mirrored;
        ev_hit[EV_SPARE]    = ecc_i.corr && ecc_i.spare_copy;
        ev_hit[EV_PATROL]   = ecc_i.corr && ecc_i.patrol && !ecc_i.spare_copy;
        ev_hit[EV_SYNC_PAR] = sync_stat_i && sync_par_err_i;
        ev_hit[EV_SPD]      = spd_err_i;
        ev_hit[EV_FRST_TMO] = frst_tmo && !tmo_suppress;
        ev_hit[EV_REFRESH]  = ack_checked && nb_i.ack_bad;
        ev_hit[EV_FRST_RED] = frst_tmo_red;
    end

    // fast-reset supervisor
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            frst_st_r  <= FBMEC_IDLE;
            frst_red_r <= 1'b0;
            frst_cnt_r <= 32'h0;
        end else begin
            case (frst_st_r)
                FBMEC_IDLE: begin
                    frst_cnt_r <= 32'h0;
                    if (frst_start_i) begin
                        frst_red_r <= frst_redund_i;
                        frst_st_r  <= FBMEC_WAIT;
                    end
                end
                FBMEC_WAIT: begin
                    if (frst_done_i || frst_cnt_r == TMO_CYC - 1) begin
                        frst_st_r <= FBMEC_DONE;
                    end else begin
                        frst_cnt_r <= frst_cnt_r + 32'h1;
                    end
                end
                FBMEC_DONE: begin
                    frst_st_r <= FBMEC_IDLE;
                end
                default: begin
                    frst_st_r <= FBMEC_IDLE;
                end
            endcase
        end
    end

    // failover mode and its log; held until reset, no auto exit
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            failover_o               <= 1'b0;
            failover_lane_log_low_o  <= '0;
            failover_lane_log_high_o <= 8'h00;
        end else if (lane_fail_i) begin
            failover_o               <= 1'b1;
            failover_lane_log_low_o  <= lane_info_i;
            if (failover_lane_log_high_o != 8'hff) begin
                failover_lane_log_high_o <= failover_lane_log_high_o + 8'h01;
            end
        end
    end

    // sync status use and alert-recovery replay; presence errors never retried
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync_use_o   <= 1'b0;
            cfg_replay_o <= 1'b0;
        end else begin
            sync_use_o   <= sync_stat_i && !sync_par_err_i;
            cfg_replay_o <= sync_stat_i && sync_for_frst_i;
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ev_sticky_o  <= EV_RST;
            sev_sticky_o <= SEV_RST;
        end else begin
            ev_sticky_o  <= (ev_sticky_o & ~ev_clr_i) | ev_hit;
            sev_sticky_o <= (sev_sticky_o & ~sev_clr_i) | fbmec_sev(ev_hit);
        end
    end

    // assertions
    sequence s_frst_wait;
        frst_st_r == FBMEC_WAIT && !frst_red_r;
    endsequence

    // non-redundant reset on its last wait cycle with no completion
    sequence s_frst_expire;
        s_frst_wait ##0 (frst_cnt_r == TMO_CYC - 1 && !frst_done_i);
    endsequence

    // fifth slot of a 4:5 window whose first four slots carried data
    sequence s_gear_full;
        gear_i == GEAR_4_5 && gear_pos_r == GEAR45_WIN - 3'h1
        && gear_data_r >= GEAR45_SLOTS;
    endsequence

    a_failover_entry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        lane_fail_i |=> failover_o && sev_sticky_o[SEV_REC_BIT])
        else $error("failover not entered");
    a_demand_corr: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ecc_i.corr && !ecc_i.spare_copy && !ecc_i.patrol)
        |=> sev_sticky_o[SEV_CORR_BIT]
            && ev_sticky_o[$past(ecc_i.mirrored) ? EV_DEM_MIR : EV_DEM_NMIR])
        else $error("demand correctable lost");
    a_spare_corr: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ecc_i.corr && ecc_i.spare_copy) |=> ev_sticky_o[EV_SPARE])
        else $error("spare copy event lost");
    a_patrol_corr: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ecc_i.corr && ecc_i.patrol && !ecc_i.spare_copy)
        |=> ev_sticky_o[EV_PATROL] && !$rose(ev_sticky_o[EV_DEM_NMIR]))
        else $error("patrol event wrong");
    a_sync_drop: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (sync_stat_i && sync_par_err_i) |=> !sync_use_o && ev_sticky_o[EV_SYNC_PAR])
        else $error("bad sync status used");
    a_sync_replay: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (sync_stat_i && sync_for_frst_i) |=> cfg_replay_o)
        else $error("replay missing");
    a_spd_corr: assert property (@(posedge core_clk_i) disable iff (reset_i)
        spd_err_i |=> ev_sticky_o[EV_SPD] && sev_sticky_o[SEV_CORR_BIT])
        else $error("presence error lost");
    a_frst_fatal: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (s_frst_wait ##0 (frst_cnt_r == TMO_CYC - 1 && !frst_done_i && !tmo_suppress))
        |=> sev_sticky_o[SEV_FATAL_BIT])
        else $error("timeout not fatal");
    a_refr_skip: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (nb_i.valid && nb_i.rd_data && nb_i.refr_ack && nb_i.ack_bad
         && !ev_sticky_o[EV_REFRESH]) |=> !ev_sticky_o[EV_REFRESH])
        else $error("refresh checked with read data");
    a_refr_err: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ack_checked && nb_i.ack_bad) |=> ev_sticky_o[EV_REFRESH] && sev_sticky_o[SEV_REC_BIT])
        else $error("refresh error lost");

    // log location follows the lane, count steps by one below saturation
    a_failover_log: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (lane_fail_i && failover_lane_log_high_o != 8'hff)
        |=> failover_lane_log_high_o == $past(failover_lane_log_high_o) + 8'h01
            && failover_lane_log_low_o == $past(lane_info_i))
        else $error("failover log not updated");
    // clean sync status is used and raises no parity event
    a_sync_use: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (sync_stat_i && !sync_par_err_i) |=> sync_use_o && !$rose(ev_sticky_o[EV_SYNC_PAR]))
        else $error("good sync status not used");
    // a reset that completes in time is never fatal
    a_frst_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (s_frst_wait ##0 (frst_done_i && !sev_sticky_o[SEV_FATAL_BIT]))
        |=> !sev_sticky_o[SEV_FATAL_BIT])
        else $error("completed reset reported fatal");
    // geared mode with double write-recovery failure hides the timeout
    a_tmo_hidden: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (s_frst_expire ##0 (tmo_suppress && !ev_sticky_o[EV_FRST_TMO]))
        |=> !ev_sticky_o[EV_FRST_TMO])
        else $error("geared timeout not hidden");
    // bad ack in an oversubscribed fifth slot is never checked
    a_gear_skip: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (s_gear_full ##0 (nb_i.valid && nb_i.refr_ack && nb_i.ack_bad
                          && !ev_sticky_o[EV_REFRESH])) |=> !ev_sticky_o[EV_REFRESH])
        else $error("oversubscribed refresh checked");
    // redundant reset expiry lands in the recoverable class
    a_frst_red_rec: assert property (@(posedge core_clk_i) disable iff (reset_i)
        frst_tmo_red |=> ev_sticky_o[EV_FRST_RED] && sev_sticky_o[SEV_REC_BIT])
        else $error("redundant timeout lost");
    // a sticky bit only falls when its clear strobe was given
    a_sticky_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> (($past(ev_sticky_o) & ~$past(ev_clr_i) & ~ev_sticky_o) == EV_RST)
                 && (($past(sev_sticky_o) & ~$past(sev_clr_i) & ~sev_sticky_o) == SEV_RST))
        else $error("sticky flag lost without clear");
    // a new event sets its flag even against a clear strobe
    a_set_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ev_hit != EV_RST) |=> ((ev_sticky_o & $past(ev_hit)) == $past(ev_hit)))
        else $error("event lost to clear");

endmodule : fbmec_classifier

`default_nettype wire

// file: verification/fbmec_dimm_model.sv
/* fbmec_dimm_model: behavioural channel pair, northbound frames, sync, fast reset.
   assumes: shares the classifier clock; the bench calls its tasks. */
`timescale 1ns/10ps
`default_nettype none
module fbmec_dimm_model
    import fbmec_pkg::*;
(
    input  wire logic      clk_i,     // core clock
    output var fbmec_nb_frame_s nb_o, // northbound frame slot
    output logic           sync_o,    // sync status frame
    output logic           par_bad_o, // its parity was bad
    output logic           done_o     // fast reset completed
);
    // quiet lines at time zero
    initial begin
        nb_o      = '0;
        sync_o    = 1'b0;
        par_bad_o = 1'b0;
        done_o    = 1'b0;
    end
    // one valid frame; calls back to back fill slots
    task automatic frame(input logic rd, input logic ack, input logic bad);
        @(posedge clk_i);
        nb_o <= {1'b1, rd, ack, bad};
    endtask : frame
    // idle slot, payload bits scrambled
    task automatic idle();
        @(posedge clk_i);
        nb_o <= {1'b0, ~nb_o[2:0]};
    endtask : idle
    // one sync status frame, parity as asked
    task automatic sync(input logic bad);
        @(posedge clk_i);
        sync_o    <= 1'b1;
        par_bad_o <= bad;
        @(posedge clk_i);
        sync_o    <= 1'b0;
        par_bad_o <= ~bad;
    endtask : sync
    // completion pulse of a fast reset
    task automatic done();
        @(posedge clk_i);
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
    endtask : done
endmodule : fbmec_dimm_model
`default_nettype wire

// file: verification/tb_top.sv
/* tb_top: self-checking bench for the error classifier.
   assumes: one 100 MHz clock; stickies set one cycle after their cause. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fbmec_pkg::*;
    localparam int unsigned TMO = 4; // short fast-reset timeout
    logic            clk = 1'b0, rst = 1'b1, lane_fail = 1'b0, for_frst = 1'b0;
    logic            spd = 1'b0, f_start = 1'b0, f_red = 1'b0, both = 1'b0;
    fbmec_fo_log_s   lane_info = '0;
    fbmec_ecc_s      ecc = '0;
    fbmec_nb_frame_s nb;
    logic [1:0]      gear = GEAR_1_1;
    logic [EV_W-1:0] ev_clr = '0, ev;
    logic [2:0]      sev_clr = '0, sev;
    logic            sync, par_bad, f_done, fo, use_s, replay;
    fbmec_fo_log_s   lo;
    logic [7:0]      hi;
    int              mismatches = 0, checks = 0;
    always #5 clk = ~clk; // 100 MHz
    fbmec_dimm_model u_dimm (.clk_i(clk), .nb_o(nb), .sync_o(sync), .par_bad_o(par_bad),
        .done_o(f_done));
    fbmec_classifier #(.TMO_CYC(TMO)) u_dut (
        .core_clk_i(clk), .reset_i(rst), .lane_fail_i(lane_fail), .lane_info_i(lane_info),
        .ecc_i(ecc), .sync_stat_i(sync), .sync_par_err_i(par_bad), .sync_for_frst_i(for_frst),
        .spd_err_i(spd), .frst_start_i(f_start), .frst_redund_i(f_red), .frst_done_i(f_done),
        .wr_recov_both_i(both), .gear_i(gear), .nb_i(nb), .ev_clr_i(ev_clr),
        .sev_clr_i(sev_clr), .failover_o(fo), .failover_lane_log_low_o(lo),
        .failover_lane_log_high_o(hi), .sync_use_o(use_s), .cfg_replay_o(replay),
        .ev_sticky_o(ev), .sev_sticky_o(sev));
    // compare one value, count and report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // judge stickies, then clear them all
    task automatic see(input logic [EV_W-1:0] e, input logic [2:0] s);
        #1;
        chk("events", e, ev);
        chk("severity", s, sev);
        @(posedge clk);
        ev_clr  <= '1;
        sev_clr <= '1;
        @(posedge clk);
        ev_clr  <= '0;
        sev_clr <= '0;
        #1 chk("cleared", 0, {ev, sev});
    endtask : see
    // lane failure enters failover and logs
    task automatic t_lane();
        @(posedge clk);
        lane_fail <= 1'b1;
        lane_info <= 7'h5a;
        @(posedge clk);
        lane_fail <= 1'b0;
        see(10'h001, 3'h2);
        chk("failover", 1, fo);
        chk("log low", 7'h5a, lo);
        chk("log high", 1, hi);
        $display("test lane done");
    endtask : t_lane
    // each read kind lands in its own event
    task automatic t_ecc();
        logic [3:0] k[4] = '{4'h8, 4'hc, 4'ha, 4'h9};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            ecc <= k[i];
            @(posedge clk);
            ecc <= '0;
            see(10'h1 << (i + 1), 3'h4);
        end
        $display("test ecc done");
    endtask : t_ecc
    // bad sync dropped, alert prep replays
    task automatic t_sync();
        @(posedge clk);
        for_frst <= 1'b1;
        u_dimm.sync(1'b1);
        #1 chk("replay", 1, replay);
        chk("sync used", 0, use_s);
        see(10'h020, 3'h4);
        @(posedge clk);
        for_frst <= 1'b0;
        u_dimm.sync(1'b0);
        #1 chk("sync used", 1, use_s);
        chk("replay", 0, replay);
        see(10'h000, 3'h0);
        $display("test sync done");
    endtask : t_sync
    // presence-detect error, no retry after
    task automatic t_spd();
        @(posedge clk);
        spd <= 1'b1;
        @(posedge clk);
        spd <= 1'b0;
        see(10'h040, 3'h4);
        // event and clear strobe in one cycle: the event wins
        @(posedge clk);
        spd    <= 1'b1;
        ev_clr <= 10'h040;
        @(posedge clk);
        spd    <= 1'b0;
        ev_clr <= '0;
        see(10'h040, 3'h4);
        repeat (10) @(posedge clk);
        #1 chk("no retry", 0, ev);
        $display("test spd done");
    endtask : t_spd
    // one fast reset, finished or left to time out
    task automatic frst(input logic r, input logic fin, input logic [1:0] g, input logic b,
                        input logic [EV_W-1:0] e, input logic [2:0] s);
        @(posedge clk);
        gear    <= g;
        both    <= b;
        f_start <= 1'b1;
        f_red   <= r;
        @(posedge clk);
        f_start <= 1'b0;
        if (fin) u_dimm.done();
        repeat (TMO + 4) @(posedge clk);
        gear <= GEAR_1_1;
        both <= 1'b0;
        see(e, s);
    endtask : frst
    // refresh acks: checked, beside data, and in the geared fifth slot
    task automatic t_refr();
        u_dimm.frame(1'b0, 1'b1, 1'b1);
        u_dimm.idle();
        see(10'h100, 3'h2);
        u_dimm.frame(1'b1, 1'b1, 1'b1);
        u_dimm.idle();
        see(10'h000, 3'h0);
        @(posedge clk);
        gear <= GEAR_4_5;
        repeat (4) u_dimm.frame(1'b1, 1'b0, 1'b0);
        u_dimm.frame(1'b0, 1'b1, 1'b1);
        u_dimm.idle();
        see(10'h000, 3'h0);
        repeat (3) u_dimm.frame(1'b1, 1'b0, 1'b0);
        u_dimm.frame(1'b0, 1'b0, 1'b0);
        u_dimm.frame(1'b0, 1'b1, 1'b1);
        u_dimm.idle();
        see(10'h100, 3'h2);
        @(posedge clk);
        gear <= GEAR_1_1;
        $display("test refresh done");
    endtask : t_refr
    // counts, verdict, end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // watchdog on a hung run
    initial begin
        #100us;
        mismatches++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset outs", 0, {fo, lo, hi, use_s, replay, ev, sev});
        t_lane();
        t_ecc();
        t_sync();
        t_spd();
        frst(1'b0, 1'b0, GEAR_1_1, 1'b0, 10'h080, 3'h1);
        frst(1'b0, 1'b1, GEAR_1_1, 1'b0, 10'h000, 3'h0);
        frst(1'b1, 1'b0, GEAR_1_1, 1'b0, 10'h200, 3'h2);
        frst(1'b0, 1'b0, GEAR_OTH, 1'b1, 10'h000, 3'h0);
        frst(1'b0, 1'b0, GEAR_OTH, 1'b0, 10'h080, 3'h1);
        $display("test fast reset done");
        t_refr();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
